/* File: logic/cds_sequencer.sv */
`timescale 1ns/100ps
module cds_sequencer #(
  parameter int STEP_CYCLES = cds_pkg::STEP_CYCLES,
  parameter logic [15:0] ROM_SUM = 16'h0000
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic TEST_SHORT,
  input wire logic KEY_VALID,
  input wire logic [2:0] KEY_CODE,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic IF_FITTED,
  input wire logic [4:0] IF_ADDR,
  input wire logic IF_TEST_DONE,
  input wire logic IF_TEST_PASS,
  input wire logic [7:0] ROM_DATA,
  input wire logic CAL_VALID,
  input wire logic [7:0] CAL_START,
  input wire logic [7:0] CAL_STOP,
  output logic [3:0] DISP_MODE,
  output logic DISP_ALL_ON,
  output logic [11:0] DISP_LEFT,
  output logic [11:0] DISP_RIGHT,
  output logic [47:0] REMOTE_CAL,
  output logic INTERP_FAULT,
  output logic IF_TEST_REQ,
  output logic IF_ERROR,
  output logic [11:0] ROM_ADDR,
  output logic RAM_ERROR,
  output logic ROM_ERROR,
  output logic PASS_DONE,
  output logic [31:0] PORT_OUT
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] to_bcd(input logic [7:0] v);
    logic [19:0] s;
    s = {12'h000, v};
    for (int i = 0; i < 8; i++) begin
      if (s[11:8] > 4'h4) s[11:8] = s[11:8] + 4'h3;
      if (s[15:12] > 4'h4) s[15:12] = s[15:12] + 4'h3;
      if (s[19:16] > 4'h4) s[19:16] = s[19:16] + 4'h3;
      s = {s[18:0], 1'b0};
    end
    return s[19:8];
  endfunction
  function automatic logic cal_bad(input logic [7:0] v, input logic [7:0] prev,
                                   input logic have_prev);
    logic [7:0] d;
    d = (v > prev) ? v - prev : prev - v;
    return (v == cds_pkg::CAL_LOW) || (v == cds_pkg::CAL_HIGH) ||
           (have_prev && (d > cds_pkg::CAL_DRIFT));
  endfunction
  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);
  localparam logic [11:0] RAM_LAST = 12'(cds_pkg::RAM_BYTES - 1);
  localparam logic [11:0] ROM_LAST = 12'(cds_pkg::ROM_BYTES - 1);
  cds_pkg::cds_state_type state_reg, state_next;
  cds_pkg::cds_phase_type phase_reg;
  logic strap_pending_reg, port_mode_reg;
  logic [11:0] idx_reg;
  logic [15:0] sum_reg;
  logic ram_bad_reg, seed_reg, rom_take_reg, pass_seen_reg, if_done_reg;
  logic [7:0] ram_mem [0:cds_pkg::RAM_BYTES-1];
  logic [7:0] pattern;
  logic [7:0] start_reg, stop_reg;
  logic have_prev_reg;
  logic [SW-1:0] step_reg;
  logic [2:0] pos_reg;
  logic up_reg;
  logic mem_run, chk, other_key;
  assign chk = KEY_VALID && (KEY_CODE == cds_pkg::KEY_CHECK);
  assign other_key = KEY_VALID && (KEY_CODE != cds_pkg::KEY_CHECK);
  assign mem_run = (state_reg == cds_pkg::CDS_POWERUP) || (state_reg == cds_pkg::CDS_MEM);
  assign pattern = idx_reg[7:0] ^ {8{seed_reg}};
  // ****************************************
  // test-point strap, caught after reset release
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      strap_pending_reg <= 1'b1;
      port_mode_reg <= 1'b0;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      port_mode_reg <= TEST_SHORT;
    end
  end
  // ****************************************
  // routine selection
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cds_pkg::CDS_POWERUP: begin
        if (port_mode_reg) begin
          state_next = cds_pkg::CDS_PORT;
        end else if (pass_seen_reg && (if_done_reg || !IF_FITTED)) begin
          state_next = cds_pkg::CDS_IDLE;
        end
      end
      cds_pkg::CDS_PORT: state_next = cds_pkg::CDS_PORT;
      cds_pkg::CDS_IDLE: begin
        if (chk) state_next = cds_pkg::CDS_REF;
      end
      cds_pkg::CDS_REF: begin
        if (chk) begin
          state_next = cds_pkg::CDS_MEM;
        end else if (other_key) begin
          state_next = cds_pkg::CDS_IDLE;
        end
      end
      default: begin
        if (KEY_VALID) begin
          case (KEY_CODE)
            cds_pkg::KEY_PERIOD: state_next = cds_pkg::CDS_ADDR;
            cds_pkg::KEY_CHAN_B: state_next = cds_pkg::CDS_SHORT;
            cds_pkg::KEY_GATE: state_next = cds_pkg::CDS_LONG;
            cds_pkg::KEY_RESET: state_next = cds_pkg::CDS_IDLE;
            default: state_next = state_reg;
          endcase
        end
      end
    endcase
    if (CMD_VALID && (state_reg != cds_pkg::CDS_POWERUP) &&
        (state_reg != cds_pkg::CDS_PORT)) begin
      case (CMD_CODE)
        cds_pkg::MEMORY_CHECK_COMMAND: state_next = cds_pkg::CDS_MEM;
        cds_pkg::INTERFACE_ADDRESS_COMMAND: state_next = cds_pkg::CDS_ADDR;
        cds_pkg::SHORT_CAL_COMMAND: state_next = cds_pkg::CDS_SHORT;
        cds_pkg::LONG_CAL_COMMAND: state_next = cds_pkg::CDS_LONG;
        default: state_next = state_next;
      endcase
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_reg <= cds_pkg::CDS_POWERUP;
      DISP_ALL_ON <= 1'b1;
    end else begin
      state_reg <= state_next;
      DISP_ALL_ON <= (state_next == cds_pkg::CDS_POWERUP);
    end
  end
  assign DISP_MODE = state_reg;
  // ****************************************
  // interface self test at power-on
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      IF_TEST_REQ <= 1'b0;
      if_done_reg <= 1'b0;
      IF_ERROR <= 1'b0;
    end else if (state_reg == cds_pkg::CDS_POWERUP) begin
      IF_TEST_REQ <= IF_FITTED && !if_done_reg && !IF_TEST_DONE;
      if (IF_TEST_DONE && IF_TEST_REQ) begin
        if_done_reg <= 1'b1;
        IF_ERROR <= !IF_TEST_PASS;
      end
    end else begin
      IF_TEST_REQ <= 1'b0;
    end
  end
  // ****************************************
  // memory check engine
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (mem_run && (phase_reg == cds_pkg::CDS_PH_WRITE)) begin
      ram_mem[idx_reg[5:0]] <= pattern;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      phase_reg <= cds_pkg::CDS_PH_WRITE;
      idx_reg <= 12'h000;
      sum_reg <= 16'h0000;
      ram_bad_reg <= 1'b0;
      seed_reg <= 1'b0;
      rom_take_reg <= 1'b0;
      ROM_ADDR <= 12'h000;
      RAM_ERROR <= 1'b0;
      ROM_ERROR <= 1'b0;
      PASS_DONE <= 1'b0;
      pass_seen_reg <= 1'b0;
    end else begin
      PASS_DONE <= 1'b0;
      rom_take_reg <= mem_run && (phase_reg == cds_pkg::CDS_PH_ROM);
      if (rom_take_reg) sum_reg <= sum_reg + {8'h00, ROM_DATA};
      if (!mem_run) begin
        phase_reg <= cds_pkg::CDS_PH_WRITE;
        idx_reg <= 12'h000;
        ram_bad_reg <= 1'b0;
      end else begin
        case (phase_reg)
          cds_pkg::CDS_PH_WRITE: begin
            idx_reg <= (idx_reg == RAM_LAST) ? 12'h000 : idx_reg + 12'h001;
            if (idx_reg == RAM_LAST) phase_reg <= cds_pkg::CDS_PH_READ;
          end
          cds_pkg::CDS_PH_READ: begin
            if (ram_mem[idx_reg[5:0]] != pattern) ram_bad_reg <= 1'b1;
            idx_reg <= (idx_reg == RAM_LAST) ? 12'h000 : idx_reg + 12'h001;
            if (idx_reg == RAM_LAST) begin
              phase_reg <= cds_pkg::CDS_PH_ROM;
              sum_reg <= 16'h0000;
            end
          end
          cds_pkg::CDS_PH_ROM: begin
            ROM_ADDR <= idx_reg;
            idx_reg <= idx_reg + 12'h001;
            if (idx_reg == ROM_LAST) phase_reg <= cds_pkg::CDS_PH_TAIL;
          end
          cds_pkg::CDS_PH_TAIL: phase_reg <= cds_pkg::CDS_PH_DONE;
          cds_pkg::CDS_PH_DONE: begin
            RAM_ERROR <= ram_bad_reg;
            ROM_ERROR <= (sum_reg != ROM_SUM);
            PASS_DONE <= 1'b1;
            pass_seen_reg <= 1'b1;
            ram_bad_reg <= 1'b0;
            seed_reg <= !seed_reg;
            idx_reg <= 12'h000;
            phase_reg <= cds_pkg::CDS_PH_WRITE;
          end
          default: phase_reg <= cds_pkg::CDS_PH_WRITE;
        endcase
      end
    end
  end
  // ****************************************
  // address and calibration display
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      start_reg <= 8'h00;
      stop_reg <= 8'h00;
      have_prev_reg <= 1'b0;
      INTERP_FAULT <= 1'b0;
    end else begin
      if (state_next != state_reg) begin
        have_prev_reg <= 1'b0;
        INTERP_FAULT <= 1'b0;
      end
      if (CAL_VALID && ((state_reg == cds_pkg::CDS_SHORT) ||
                        (state_reg == cds_pkg::CDS_LONG))) begin
        start_reg <= CAL_START;
        stop_reg <= CAL_STOP;
        have_prev_reg <= (state_next == state_reg);
        if (cal_bad(CAL_START, start_reg, have_prev_reg) ||
            cal_bad(CAL_STOP, stop_reg, have_prev_reg)) begin
          INTERP_FAULT <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DISP_LEFT <= {3{cds_pkg::DIGIT_SPACE}};
      DISP_RIGHT <= {3{cds_pkg::DIGIT_SPACE}};
      REMOTE_CAL <= {12{cds_pkg::DIGIT_SPACE}};
    end else begin
      case (state_reg)
        cds_pkg::CDS_ADDR: begin
          DISP_LEFT <= {3{cds_pkg::DIGIT_SPACE}};
          if (IF_FITTED) begin
            DISP_RIGHT <= {cds_pkg::DIGIT_SPACE, 8'(to_bcd({3'h0, IF_ADDR}))};
          end else begin
            DISP_RIGHT <= {cds_pkg::DIGIT_SPACE, {2{cds_pkg::DIGIT_DASH}}};
          end
        end
        cds_pkg::CDS_SHORT, cds_pkg::CDS_LONG: begin
          DISP_LEFT <= to_bcd(start_reg);
          DISP_RIGHT <= to_bcd(stop_reg);
          REMOTE_CAL <= {{2{cds_pkg::DIGIT_SPACE}}, to_bcd(start_reg),
                         {4{cds_pkg::DIGIT_SPACE}}, to_bcd(stop_reg)};
        end
        default: begin
          DISP_LEFT <= {3{cds_pkg::DIGIT_SPACE}};
          DISP_RIGHT <= {3{cds_pkg::DIGIT_SPACE}};
        end
      endcase
    end
  end
  // ****************************************
  // port walking test
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      step_reg <= '0;
      pos_reg <= cds_pkg::LOWEST_PORT_LINE;
      up_reg <= 1'b1;
      PORT_OUT <= {4{cds_pkg::PORT_IDLE}};
    end else if (state_reg == cds_pkg::CDS_PORT) begin
      PORT_OUT <= {4{~(cds_pkg::PORT_LOW_BIT << pos_reg)}};
      step_reg <= (step_reg == STEP_LAST) ? '0 : step_reg + SW'(1);
      if (step_reg == STEP_LAST) begin
        if (up_reg && (pos_reg == cds_pkg::HIGHEST_PORT_LINE)) begin
          up_reg <= 1'b0;
          pos_reg <= pos_reg - 3'h1;
        end else if (!up_reg && (pos_reg == cds_pkg::LOWEST_PORT_LINE)) begin
          up_reg <= 1'b1;
          pos_reg <= pos_reg + 3'h1;
        end else begin
          pos_reg <= up_reg ? pos_reg + 3'h1 : pos_reg - 3'h1;
        end
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence s_ref_check;
    (state_reg == cds_pkg::CDS_REF) && chk && !CMD_VALID;
  endsequence
  sequence s_idle_check;
    (state_reg == cds_pkg::CDS_IDLE) && chk && !CMD_VALID;
  endsequence
  property p_starburst;
    @(posedge CLOCK) $fell(RESET) |-> DISP_ALL_ON [*2];
  endproperty
  a_starburst: assert property (p_starburst) else $error("display not all on");
  property p_no_return;
    @(posedge CLOCK) disable iff (RESET)
      (state_reg != cds_pkg::CDS_POWERUP) |=> (state_reg != cds_pkg::CDS_POWERUP);
  endproperty
  a_no_return: assert property (p_no_return) else $error("power-on reentered");
  property p_enter_diag;
    @(posedge CLOCK) disable iff (RESET)
      s_idle_check ##[1:2] s_ref_check |=> (state_reg == cds_pkg::CDS_MEM);
  endproperty
  a_enter_diag: assert property (p_enter_diag) else $error("no memory check");
  property p_other_key;
    @(posedge CLOCK) disable iff (RESET)
      (state_reg == cds_pkg::CDS_REF) && other_key && !CMD_VALID
      |=> (state_reg == cds_pkg::CDS_IDLE);
  endproperty
  a_other_key: assert property (p_other_key) else $error("other key ignored");
  property p_remote_mem;
    @(posedge CLOCK) disable iff (RESET)
      CMD_VALID && (CMD_CODE == cds_pkg::MEMORY_CHECK_COMMAND) &&
      (state_reg == cds_pkg::CDS_IDLE) |=> (state_reg == cds_pkg::CDS_MEM);
  endproperty
  a_remote_mem: assert property (p_remote_mem) else $error("remote select lost");
  property p_dashes;
    @(posedge CLOCK) disable iff (RESET)
      (state_reg == cds_pkg::CDS_ADDR) && !IF_FITTED
      |=> (DISP_RIGHT[7:0] == {2{cds_pkg::DIGIT_DASH}});
  endproperty
  a_dashes: assert property (p_dashes) else $error("dashes missing");
  property p_cal_fault;
    @(posedge CLOCK) disable iff (RESET)
      CAL_VALID && (state_reg == cds_pkg::CDS_SHORT) && (state_next == state_reg) &&
      (CAL_START == cds_pkg::CAL_HIGH) |=> INTERP_FAULT;
  endproperty
  a_cal_fault: assert property (p_cal_fault) else $error("fault not flagged");
  property p_one_low;
    @(posedge CLOCK) disable iff (RESET)
      (state_reg == cds_pkg::CDS_PORT) ##1 (state_reg == cds_pkg::CDS_PORT)
      |-> ($countones(PORT_OUT[7:0]) == 7) && (PORT_OUT[15:8] == PORT_OUT[7:0]) &&
          (PORT_OUT[31:16] == PORT_OUT[15:0]);
  endproperty
  a_one_low: assert property (p_one_low) else $error("port pattern wrong");
  property p_walk;
    @(posedge CLOCK) disable iff (RESET)
      (state_reg == cds_pkg::CDS_PORT) && (step_reg == STEP_LAST) && up_reg &&
      (pos_reg != cds_pkg::HIGHEST_PORT_LINE) |=> (pos_reg == $past(pos_reg) + 3'h1);
  endproperty
  a_walk: assert property (p_walk) else $error("walk step wrong");
endmodule // cds_sequencer

/* File: logic/cds_pkg.sv */
package cds_pkg;
  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int RAM_BYTES = 64;
  localparam int ROM_BYTES = 4032;
  localparam int CLOCK_HZ = 50000000;
  localparam int STEP_TIME_MS = 100;
  localparam int STEP_CYCLES = CLOCK_HZ / 1000 * STEP_TIME_MS;
  localparam logic [7:0] CAL_LOW = 8'h00;
  localparam logic [7:0] CAL_HIGH = 8'hFF;
  localparam logic [7:0] CAL_DRIFT = 8'h03;
  // ****************************************
  // keys, commands, display codes
  // ****************************************
  localparam logic [2:0] KEY_CHECK = 3'h1;
  localparam logic [2:0] KEY_PERIOD = 3'h2;
  localparam logic [2:0] KEY_CHAN_B = 3'h3;
  localparam logic [2:0] KEY_GATE = 3'h4;
  localparam logic [2:0] KEY_RESET = 3'h5;
  localparam logic [7:0] MEMORY_CHECK_COMMAND = 8'h0B;
  localparam logic [7:0] INTERFACE_ADDRESS_COMMAND = 8'h0C;
  localparam logic [7:0] SHORT_CAL_COMMAND = 8'h0D;
  localparam logic [7:0] LONG_CAL_COMMAND = 8'h0E;
  localparam logic [3:0] DIGIT_DASH = 4'hA;
  localparam logic [3:0] DIGIT_SPACE = 4'hF;
  localparam logic [7:0] PORT_IDLE = 8'hFF;
  localparam logic [7:0] PORT_LOW_BIT = 8'h01;
  localparam logic [2:0] LOWEST_PORT_LINE = 3'h0;
  localparam logic [2:0] HIGHEST_PORT_LINE = 3'h7;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [3:0] {
    CDS_POWERUP = 4'h0,
    CDS_IDLE = 4'h1,
    CDS_REF = 4'h2,
    CDS_MEM = 4'h3,
    CDS_ADDR = 4'h4,
    CDS_SHORT = 4'h5,
    CDS_LONG = 4'h6,
    CDS_PORT = 4'h7
  } cds_state_type;
  typedef enum logic [2:0] {
    CDS_PH_WRITE = 3'h0,
    CDS_PH_READ = 3'h1,
    CDS_PH_ROM = 3'h2,
    CDS_PH_TAIL = 3'h3,
    CDS_PH_DONE = 3'h4
  } cds_phase_type;
endpackage

/* File: tb/cds_remote_model.sv */
`timescale 1ns/100ps
module cds_remote_model (
  input wire logic clock,
  input wire logic if_test_req,
  output logic if_test_done,
  output logic if_test_pass,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  // ****************************************
  // remote controller behaviour
  // ****************************************
  int resp_delay = 25;
  int wait_count = 0;
  logic answered = 1'b0;
  logic pend = 1'b0;
  logic [7:0] pend_code = 8'h00;

  initial begin
    if_test_done = 1'b0;
    if_test_pass = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h5A;
  end

  // answers the power-on interface test after a chosen delay
  always @(posedge clock) begin
    if_test_done <= 1'b0;
    if_test_pass <= ~if_test_pass;
    if (if_test_req !== 1'b1) begin
      wait_count <= 0;
      answered <= 1'b0;
    end else if (!answered) begin
      if (wait_count == resp_delay) begin
        if_test_done <= 1'b1;
        if_test_pass <= 1'b1;
        answered <= 1'b1;
      end else begin
        wait_count <= wait_count + 1;
      end
    end
  end

  // command code is junk whenever no command is offered
  always @(posedge clock) begin
    if (pend) begin
      cmd_valid <= 1'b1;
      cmd_code <= pend_code;
      pend = 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_code <= cmd_code ^ 8'hA5;
    end
  end

  task automatic send_cmd(input logic [7:0] code);
    pend_code = code;
    pend = 1'b1;
    @(posedge clock);
    @(posedge clock);
    #1;
  endtask
endmodule // cds_remote_model

/* File: tb/counter_diagnostic_sequencer_tb_top.sv */
`timescale 1ns/100ps
module counter_diagnostic_sequencer_tb_top;
  localparam int STEP = 4;
  localparam int LIMIT = 60000;
  logic clock, reset, test_short, key_valid, if_fitted, if_test_done, if_test_pass;
  logic cmd_valid, cal_valid, disp_all_on, interp_fault, if_test_req, if_error;
  logic ram_error, rom_error, pass_done, rom_bad;
  logic [2:0] key_code;
  logic [7:0] cmd_code, rom_data, cal_start, cal_stop;
  logic [4:0] if_addr;
  logic [3:0] disp_mode;
  logic [11:0] disp_left, disp_right, rom_addr;
  logic [47:0] remote_cal;
  logic [31:0] port_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  cds_sequencer #(.STEP_CYCLES(STEP), .ROM_SUM(16'hC020)) uut (
    .CLOCK(clock), .RESET(reset), .TEST_SHORT(test_short), .KEY_VALID(key_valid),
    .KEY_CODE(key_code), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .IF_FITTED(if_fitted), .IF_ADDR(if_addr), .IF_TEST_DONE(if_test_done),
    .IF_TEST_PASS(if_test_pass), .ROM_DATA(rom_data), .CAL_VALID(cal_valid),
    .CAL_START(cal_start), .CAL_STOP(cal_stop), .DISP_MODE(disp_mode),
    .DISP_ALL_ON(disp_all_on), .DISP_LEFT(disp_left), .DISP_RIGHT(disp_right),
    .REMOTE_CAL(remote_cal), .INTERP_FAULT(interp_fault), .IF_TEST_REQ(if_test_req),
    .IF_ERROR(if_error), .ROM_ADDR(rom_addr), .RAM_ERROR(ram_error),
    .ROM_ERROR(rom_error), .PASS_DONE(pass_done), .PORT_OUT(port_out));

  cds_remote_model rmt (.clock(clock), .if_test_req(if_test_req),
    .if_test_done(if_test_done), .if_test_pass(if_test_pass),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code));

  // ****************************************
  // clock, program store, watchdog
  // ****************************************
  always #10 clock = ~clock;

  // byte value is the low address byte, so the expected sum is 16'hC020;
  // the byte follows the address within the cycle, as the summing logic takes it
  assign rom_data = rom_addr[7:0] ^ {7'h00, rom_bad && rom_addr == 12'h005};

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("CHECK FAILED %0t run timed out", $time);
      wrap_up();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] bcd3(input logic [7:0] v);
    return {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction

  task automatic key_to(input logic [2:0] code, input logic [3:0] m);
    @(posedge clock);
    key_valid <= 1'b1;
    key_code <= code;
    @(posedge clock);
    key_valid <= 1'b0;
    key_code <= ~code;
    #1;
    if (m !== 4'hF) chk(disp_mode === m, "mode after key");
  endtask

  task automatic cmd_to(input logic [7:0] code, input logic [3:0] m);
    rmt.send_cmd(code);
    chk(disp_mode === m, "mode after command");
  endtask

  task automatic wait_mode(input logic [3:0] m);
    int n;
    n = 0;
    while (disp_mode !== m && n < 6000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(disp_mode === m, "mode not reached");
  endtask

  task automatic wait_pass();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (pass_done !== 1'b1 && n < 6000);
    chk(pass_done === 1'b1, "memory pass missing");
    chk(rom_addr === 12'(cds_pkg::ROM_BYTES - 1), "program scan end");
  endtask

  task automatic do_reset(input logic strap, input logic fitted);
    @(posedge clock);
    reset <= 1'b1;
    test_short <= strap;
    if_fitted <= fitted;
    repeat (3) @(posedge clock);
    #1;
    chk(disp_all_on === 1'b1 && port_out === 32'hFFFFFFFF, "reset values");
    @(posedge clock);
    reset <= 1'b0;
    #1;
  endtask

  task automatic addr_view(input logic fit, input logic [4:0] a, input logic [11:0] exp);
    @(posedge clock);
    if_fitted <= fit;
    if_addr <= a;
    repeat (2) @(posedge clock);
    #1;
    chk(disp_right === exp, "address view");
  endtask

  task automatic cal_step(input logic [7:0] st, input logic [7:0] sp, input logic fault);
    @(posedge clock);
    cal_valid <= 1'b1;
    cal_start <= st;
    cal_stop <= sp;
    @(posedge clock);
    cal_valid <= 1'b0;
    cal_start <= ~st;
    cal_stop <= ~sp;
    repeat (3) @(posedge clock);
    #1;
    chk(disp_left === bcd3(st) && disp_right === bcd3(sp), "cal display");
    chk(remote_cal === {{2{cds_pkg::DIGIT_SPACE}}, bcd3(st),
        {4{cds_pkg::DIGIT_SPACE}}, bcd3(sp)}, "cal string");
    chk(interp_fault === fault, "cal fault");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on();
    do_reset(1'b0, 1'b1);
    key_to(cds_pkg::KEY_CHECK, 4'h0);
    chk(disp_all_on === 1'b1, "segments on");
    chk(if_test_req === 1'b1, "interface test request");
    wait_mode(4'h1);
    chk(disp_all_on === 1'b0 && if_test_req === 1'b0 && if_error === 1'b0, "power end");
    chk(ram_error === 1'b0 && rom_error === 1'b0, "power memory check");
  endtask

  task automatic t_keys();
    key_to(cds_pkg::KEY_CHECK, 4'h2);
    key_to(3'h6, 4'h1);
    key_to(cds_pkg::KEY_CHECK, 4'h2);
    key_to(cds_pkg::KEY_CHECK, 4'h3);
    key_to(cds_pkg::KEY_PERIOD, 4'h4);
    addr_view(1'b1, 5'h03, {cds_pkg::DIGIT_SPACE, 8'h03});
    addr_view(1'b1, 5'h1B, {cds_pkg::DIGIT_SPACE, 8'h27});
    addr_view(1'b0, 5'h1B, {cds_pkg::DIGIT_SPACE, {2{cds_pkg::DIGIT_DASH}}});
    addr_view(1'b1, 5'h03, {cds_pkg::DIGIT_SPACE, 8'h03});
    key_to(cds_pkg::KEY_CHAN_B, 4'h5);
    key_to(cds_pkg::KEY_CHECK, 4'h5);
    key_to(cds_pkg::KEY_GATE, 4'h6);
    key_to(cds_pkg::KEY_RESET, 4'h1);
  endtask

  task automatic t_remote();
    logic [7:0] codes [4];
    codes = '{cds_pkg::MEMORY_CHECK_COMMAND, cds_pkg::INTERFACE_ADDRESS_COMMAND,
              cds_pkg::SHORT_CAL_COMMAND, cds_pkg::LONG_CAL_COMMAND};
    for (int i = 0; i < 4; i++) begin
      cmd_to(codes[i], 4'(3 + i));
    end
    cmd_to(8'h0F, 4'h6);
    cmd_to(8'h00, 4'h6);
  endtask

  task automatic t_mem();
    cmd_to(cds_pkg::MEMORY_CHECK_COMMAND, 4'h3);
    wait_pass();
    wait_pass();
    chk(ram_error === 1'b0 && rom_error === 1'b0, "clean pass");
    rom_bad = 1'b1;
    wait_pass();
    wait_pass();
    chk(rom_error === 1'b1 && disp_mode === 4'h3, "sum mismatch");
    rom_bad = 1'b0;
    wait_pass();
    wait_pass();
    chk(rom_error === 1'b0 && ram_error === 1'b0, "sum restored");
  endtask

  task automatic t_cal();
    cmd_to(cds_pkg::SHORT_CAL_COMMAND, 4'h5);
    cal_step(8'h64, 8'hC8, 1'b0);
    cal_step(8'h67, 8'hC5, 1'b0);
    cal_step(8'h6B, 8'hC5, 1'b1);
    cmd_to(cds_pkg::LONG_CAL_COMMAND, 4'h6);
    chk(interp_fault === 1'b0, "fault cleared");
    cal_step(8'h00, 8'h80, 1'b1);
    cmd_to(cds_pkg::SHORT_CAL_COMMAND, 4'h5);
    cal_step(8'hFF, 8'h64, 1'b1);
    cmd_to(cds_pkg::LONG_CAL_COMMAND, 4'h6);
    cal_step(8'h01, 8'hFE, 1'b0);
    cmd_to(cds_pkg::SHORT_CAL_COMMAND, 4'h5);
    cal_step(8'h64, 8'h00, 1'b1);
  endtask

  task automatic t_walk();
    int p [18];
    int n;
    logic [31:0] prev;
    logic lo, hi;
    lo = 1'b0;
    hi = 1'b0;
    for (int i = 0; i < 18; i++) begin
      prev = port_out;
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (port_out === prev && n < 40);
      if (i > 0) chk(n == STEP, "step interval");
      p[i] = -1;
      for (int k = 0; k < 8; k++) if (port_out[7:0] === ~(8'h01 << k)) p[i] = k;
      chk(p[i] >= 0, "one low line");
      chk(port_out === {4{port_out[7:0]}}, "ports equal");
      lo = lo | (p[i] == 0);
      hi = hi | (p[i] == 7);
    end
    for (int i = 1; i < 18; i++) begin
      chk((p[i] - p[i-1]) * (p[i] - p[i-1]) == 1, "walk step");
      if (i > 1 && p[i-1] > 0 && p[i-1] < 7) chk(p[i] - p[i-1] == p[i-1] - p[i-2], "walk dir");
    end
    chk(lo && hi, "walk reaches both ends");
  endtask

  task automatic t_port();
    do_reset(1'b1, 1'b0);
    repeat (8) @(posedge clock);
    #1;
    chk(if_test_req === 1'b0, "no interface test");
    wait_mode(4'h7);
    key_to(cds_pkg::KEY_CHECK, 4'h7);
    cmd_to(cds_pkg::MEMORY_CHECK_COMMAND, 4'h7);
    t_walk();
    do_reset(1'b0, 1'b0);
    wait_mode(4'h1);
    chk(port_out === 32'hFFFFFFFF, "ports released");
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    test_short = 1'b0;
    key_valid = 1'b0;
    key_code = 3'h0;
    if_fitted = 1'b1;
    if_addr = 5'h03;
    cal_valid = 1'b0;
    cal_start = 8'h00;
    cal_stop = 8'h00;
    rom_bad = 1'b0;
    repeat (3) @(posedge clock);
    t_power_on();
    t_keys();
    t_remote();
    t_mem();
    t_cal();
    t_port();
    wrap_up();
  end
endmodule // counter_diagnostic_sequencer_tb_top
